// file: cpdo_defaults.sv
`timescale 1ns/1ps
module cpdo_defaults
    import cpdo_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic [31:0]               hrdata,
    output logic                      hresp,
    input  wire cpdo_strap_type       strap_pin,
    input  wire logic [NUM_DIR-1:0]   app_event,
    input  wire logic                 rtr_valid,
    input  wire logic [4:0]           rtr_pdo,
    input  wire logic                 rx_valid,
    input  wire logic [CAN_W-1:0]     rx_cob,
    output logic [NUM_DIR-1:0]        tx_req,
    output logic                      rtr_send,
    output logic [4:0]                rtr_send_pdo,
    output logic                      rx_hit,
    output logic [4:0]                rx_pdo
);
    cpdo_strap_type    strap_meta_reg;
    cpdo_strap_type    strap_reg;
    logic [1:0]        init_cnt_reg;
    logic              restore_reg;
    logic              load;
    logic [31:0]       cob_reg [NUM_PDO];
    logic [7:0]        tt_reg [NUM_PDO];
    cpdo_map_type      map_reg [NUM_PDO];
    logic [31:0]       def_cob [NUM_PDO];
    logic [31:0]       pre_cob [NUM_PDO];
    cpdo_map_type      def_map [NUM_PDO];
    logic [NUM_PDO-1:0] active;
    logic [NUM_DIR-1:0] tx_ok;
    logic [NUM_DIR-1:0] rx_match;
    logic              take;
    logic              act_reg;
    logic              wr_reg;
    logic [1:0]        region_reg;
    logic [IDX_W-1:0]  idx_reg;
    logic              hreadyout_reg;
    logic [31:0]       hrdata_reg;
    logic              done;
    logic              wr_cob;
    logic              wr_map;
    logic              map_bad;
    logic              map_err_reg;
    logic [31:0]       rd_next;
    logic [NUM_DIR-1:0] tx_req_reg;
    logic              rtr_send_reg;
    logic [4:0]        rtr_pdo_reg;
    logic              rx_hit_reg;
    logic [4:0]        rx_pdo_reg;
    logic [4:0]        rx_first;
    cpdo_map_type      wmap;

    assign hreadyout    = hreadyout_reg;
    assign hrdata       = hrdata_reg;
    assign tx_req       = tx_req_reg;
    assign rtr_send     = rtr_send_reg;
    assign rtr_send_pdo = rtr_pdo_reg;
    assign rx_hit       = rx_hit_reg;
    assign rx_pdo       = rx_pdo_reg;

    // strap synchroniser
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            strap_meta_reg <= '0;
            strap_reg      <= '0;
        end else begin
            strap_meta_reg <= strap_pin;
            strap_reg      <= strap_meta_reg;
        end
    end

    // defaults load after reset release and on restore command
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            init_cnt_reg <= INIT_CYCLES;
        end else if (init_cnt_reg != '0) begin
            init_cnt_reg <= init_cnt_reg - INIT_LAST;
        end
    end
    assign load = (init_cnt_reg == INIT_LAST) || restore_reg;

    // per entry defaults, activity and transmit qualification
    for (genvar k = 0; k < NUM_PDO; k++) begin : g_pdo
        localparam int  P  = k % NUM_DIR;
        localparam bit  TX = (k < NUM_DIR);
        localparam int  G  = P % GRP_SIZE;
        logic [31:0] nid;
        logic [31:0] off;
        assign nid = 32'(strap_reg.node_id);
        assign off = COB_STEP * 32'(G);
        assign active[k] = cob_reg[k][TOP_HI:TOP_LO] < ACTIVE_LIMIT;
        always_comb begin
            pre_cob[k] = COB_INVALID;
            def_cob[k] = COB_INVALID;
            def_map[k] = '0;
            if (TX && P < STD_END) begin
                pre_cob[k] = TX_STD_BASE + off + nid;
                if (strap_reg.io[(P == 0) ? IO_DIG_IN : IO_ANA_IN]) begin
                    def_cob[k] = pre_cob[k];
                    def_map[k] = '{bits: MAP_FULL_BITS,
                                   count: (P == 0) ? MAP_DIG_CNT : MAP_ANA_CNT};
                end else begin
                    def_cob[k] = COB_INVALID | pre_cob[k];
                end
            end else if (!TX && P < STD_END) begin
                pre_cob[k] = RX_STD_BASE + off + nid;
                if (strap_reg.io[(P == 0) ? IO_DIG_OUT : IO_ANA_OUT]) begin
                    def_cob[k] = pre_cob[k];
                    def_map[k] = '{bits: MAP_FULL_BITS,
                                   count: (P == 0) ? MAP_DIG_CNT : MAP_ANA_CNT};
                end else begin
                    def_cob[k] = COB_INVALID | pre_cob[k];
                end
            end else if (TX && P < DIG_END) begin
                def_cob[k] = ((P < DIG_SPLIT) ? COB_INVALID : COB_INV_NORTR)
                             + TX_DIG_BASE + off + nid;
                if (strap_reg.io[IO_DIG_IN]) begin
                    def_map[k] = '{bits: MAP_FULL_BITS, count: MAP_DIG_CNT};
                end
            end else if (TX && P < ENC_END) begin
                def_cob[k] = COB_INV_NORTR + TX_ENC_BASE + off + nid;
                if (strap_reg.io[IO_ENC]) begin
                    def_map[k] = '{bits: MAP_FULL_BITS, count: MAP_ENC_CNT};
                end
            end else if (TX && P < ANA_END) begin
                def_cob[k] = COB_INV_NORTR + TX_ANA_BASE + off + nid;
                if (strap_reg.io[IO_ANA_IN]) begin
                    def_map[k] = '{bits: MAP_FULL_BITS, count: MAP_ANA_CNT};
                end
            end else if (TX && (P == SER_A || P == SER_B)) begin
                def_cob[k] = COB_INV_NORTR;
                if (strap_reg.io[IO_SER]) begin
                    def_map[k] = '{bits: MAP_FULL_BITS, count: MAP_SER_CNT};
                end
            end
        end
        if (TX) begin : g_tx
            assign tx_ok[P] = active[k] && (tt_reg[k] == TT_EVENT);
        end else begin : g_rx
            assign rx_match[P] = active[k] && (cob_reg[k][CAN_W-1:0] == rx_cob);
        end
    end

    // bus slave: one wait state per transfer
    assign take = hsel && htrans[1] && hready;
    assign done = act_reg;
    assign wr_cob = done && wr_reg && region_reg == REGION_COB;
    assign wr_map = done && wr_reg && region_reg == REGION_MAP;
    assign wmap = '{bits: hwdata[MAP_BITS_LO +: 7], count: hwdata[MAP_CNT_LO +: 7]};
    assign map_bad = (wmap.bits > MAP_MAX) || (wmap.count > MAP_MAX);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            act_reg    <= 1'b0;
            wr_reg     <= 1'b0;
            region_reg <= REGION_COB;
            idx_reg    <= '0;
        end else if (take) begin
            act_reg    <= 1'b1;
            wr_reg     <= hwrite;
            region_reg <= haddr[REG_HI:REG_LO];
            idx_reg    <= haddr[IDX_HI:IDX_LO];
        end else begin
            act_reg    <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hreadyout_reg <= 1'b0;
        end else if (init_cnt_reg == INIT_LAST || done) begin
            hreadyout_reg <= 1'b1;
        end else if (take) begin
            hreadyout_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hresp <= HRESP_OKAY;
        end else begin
            hresp <= HRESP_OKAY;
        end
    end

    always_comb begin
        rd_next = '0;
        unique case (region_reg)
            REGION_COB: rd_next = cob_reg[idx_reg];
            REGION_TT:  rd_next = {24'h00_0000, tt_reg[idx_reg]};
            REGION_MAP: rd_next = {9'h000, map_reg[idx_reg].bits,
                                   9'h000, map_reg[idx_reg].count};
            REGION_CTL: begin
                if (idx_reg == STAT_IDX) begin
                    rd_next = {15'h0000, map_err_reg, 2'h0, strap_reg.io,
                               1'b0, strap_reg.node_id};
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hrdata_reg <= '0;
        end else if (done && !wr_reg) begin
            hrdata_reg <= rd_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            restore_reg <= 1'b0;
        end else begin
            restore_reg <= done && wr_reg && region_reg == REGION_CTL
                           && idx_reg == CTL_IDX && hwdata[RESTORE_BIT];
        end
    end

    // identifier table
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_PDO; i++) begin
                cob_reg[i] <= '0;
            end
        end else if (load) begin
            for (int i = 0; i < NUM_PDO; i++) begin
                cob_reg[i] <= def_cob[i];
            end
        end else if (wr_cob) begin
            if (hwdata == '0 && idx_reg[4:0] < STD_END_V) begin
                cob_reg[idx_reg] <= pre_cob[idx_reg];
            end else begin
                cob_reg[idx_reg] <= hwdata;
            end
        end
    end

    // transmission types
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_PDO; i++) begin
                tt_reg[i] <= '0;
            end
        end else if (load) begin
            for (int i = 0; i < NUM_PDO; i++) begin
                tt_reg[i] <= TT_EVENT;
            end
        end else if (done && wr_reg && region_reg == REGION_TT) begin
            tt_reg[idx_reg] <= hwdata[7:0];
        end
    end

    // mapping table
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_PDO; i++) begin
                map_reg[i] <= '0;
            end
        end else if (load) begin
            for (int i = 0; i < NUM_PDO; i++) begin
                map_reg[i] <= def_map[i];
            end
        end else if (wr_map && !map_bad) begin
            map_reg[idx_reg] <= wmap;
        end
    end

    // mapping error flag, set wins over clear
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            map_err_reg <= 1'b0;
        end else if (wr_map && map_bad) begin
            map_err_reg <= 1'b1;
        end else if (done && wr_reg && region_reg == REGION_CTL && idx_reg == STAT_IDX
                     && hwdata[MAP_ERR_BIT]) begin
            map_err_reg <= 1'b0;
        end
    end

    // event transmit and remote request handling
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tx_req_reg <= '0;
        end else begin
            tx_req_reg <= app_event & tx_ok;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rtr_send_reg <= 1'b0;
            rtr_pdo_reg  <= '0;
        end else begin
            rtr_send_reg <= rtr_valid && active[rtr_pdo]
                            && !cob_reg[rtr_pdo][NORTR_BIT];
            rtr_pdo_reg  <= rtr_pdo;
        end
    end

    always_comb begin
        rx_first = '0;
        for (int i = NUM_DIR - 1; i >= 0; i--) begin
            if (rx_match[i]) begin
                rx_first = 5'(i);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rx_hit_reg <= 1'b0;
            rx_pdo_reg <= '0;
        end else begin
            rx_hit_reg <= rx_valid && (|rx_match);
            rx_pdo_reg <= rx_first;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    revert_zero_a: assert property (wr_cob && hwdata == '0 && idx_reg[4:0] < STD_END_V
        |=> cob_reg[$past(idx_reg)] == $past(pre_cob[idx_reg]))
        else $error("zero write did not restore predefined identifier");
    tx_event_a: assert property (app_event[0] && active[0] && tt_reg[0] == TT_EVENT
        |=> tx_req_reg[0])
        else $error("event transmit request mismatch");
    tx_invalid_a: assert property (cob_reg[0][INVALID_BIT] && app_event[0]
        |=> !tx_req_reg[0])
        else $error("invalid pdo requested for transmit");
    rtr_block_a: assert property (rtr_valid && cob_reg[rtr_pdo][NORTR_BIT]
        |=> !rtr_send_reg)
        else $error("remote request served despite block bit");
    rx_inactive_a: assert property (rx_valid && !(|rx_match) |=> !rx_hit_reg)
        else $error("frame accepted with no active receive pdo");
    std_default_a: assert property (load && strap_reg.io[IO_DIG_IN]
        |=> cob_reg[0] == TX_STD_BASE + 32'($past(strap_reg.node_id)))
        else $error("transmit pdo 1 default identifier wrong");
    rx_default_a: assert property (load && strap_reg.io[IO_DIG_OUT]
        |=> cob_reg[NUM_DIR] == RX_STD_BASE + 32'($past(strap_reg.node_id)))
        else $error("receive pdo 1 default identifier wrong");
    absent_io_a: assert property (load && !strap_reg.io[IO_ANA_IN]
        |=> !active[1] && map_reg[1] == '0)
        else $error("standard pdo active without its i/o");
    vendor_off_a: assert property (load |=> active[ANA_END-1:STD_END] == '0
        && tt_reg[STD_END] == TT_EVENT && cob_reg[SER_A] == COB_INV_NORTR)
        else $error("vendor pdo defaults wrong");
    top_digit_a: assert property (load |=> cob_reg[DIG_SPLIT][TOP_HI:TOP_LO] == 4'hc
        && cob_reg[STD_END][TOP_HI:TOP_LO] == 4'h8)
        else $error("vendor pdo top digit wrong");
    map_limit_a: assert property (wr_map && map_bad
        |=> map_reg[$past(idx_reg)] == $past(map_reg[idx_reg]) && map_err_reg)
        else $error("oversized mapping accepted");
    bus_wait_a: assert property (take |=> !hreadyout_reg ##1 hreadyout_reg)
        else $error("bus answer not after one wait state");

    write_c: cover property (take && hwrite ##2 hreadyout_reg);
    tx_c: cover property (|tx_req_reg);
    rx_c: cover property (rx_hit_reg);
    restore_c: cover property (restore_reg);
endmodule

// file: cpdo_partner.sv
`timescale 1ns/1ps
// can master side: remote requests and received frame identifiers
module cpdo_partner
    import cpdo_pkg::*;
(
    input  wire logic         clk,
    output logic              rtr_valid,
    output logic [4:0]        rtr_pdo,
    output logic              rx_valid,
    output logic [CAN_W-1:0]  rx_cob
);
    initial begin
        rtr_valid = 1'b0;
        rtr_pdo   = 5'h00;
        rx_valid  = 1'b0;
        rx_cob    = 11'h000;
    end

    // gap idles the master; fields scrambled once the pulse is over
    task automatic send_rtr(input logic [4:0] p, input int gap);
        repeat (gap) @(posedge clk);
        rtr_valid <= 1'b1;
        rtr_pdo   <= p;
        @(posedge clk);
        rtr_valid <= 1'b0;
        rtr_pdo   <= ~p;
    endtask

    task automatic send_frame(input logic [CAN_W-1:0] c, input int gap);
        repeat (gap) @(posedge clk);
        rx_valid <= 1'b1;
        rx_cob   <= c;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_cob   <= ~c;
    endtask
endmodule

// file: cpdo_pkg.sv
package cpdo_pkg;
    localparam int NUM_DIR = 32;
    localparam int NUM_PDO = 64;
    localparam int IDX_W   = 6;
    localparam int NODE_W  = 7;
    localparam int IO_W    = 6;
    localparam int CAN_W   = 11;

    // identifier field layout
    localparam int INVALID_BIT = 31;
    localparam int NORTR_BIT   = 30;
    localparam int TOP_HI      = 31;
    localparam int TOP_LO      = 28;
    localparam logic [3:0] ACTIVE_LIMIT = 4'h7;

    localparam logic [31:0] COB_INVALID   = 32'h8000_0000;
    localparam logic [31:0] COB_INV_NORTR = 32'hc000_0000;
    localparam logic [31:0] TX_STD_BASE   = 32'h0000_0180;
    localparam logic [31:0] RX_STD_BASE   = 32'h0000_0200;
    localparam logic [31:0] TX_DIG_BASE   = 32'h0000_01c0;
    localparam logic [31:0] TX_ENC_BASE   = 32'h0000_01e0;
    localparam logic [31:0] TX_ANA_BASE   = 32'h0000_01a0;
    localparam logic [31:0] COB_STEP      = 32'h0000_0100;

    // pdo number groups, zero based within one direction
    localparam int GRP_SIZE  = 4;
    localparam int STD_END   = 4;
    localparam int DIG_SPLIT = 6;
    localparam int DIG_END   = 8;
    localparam int ENC_END   = 12;
    localparam int ANA_END   = 16;
    localparam int SER_A     = 17;
    localparam int SER_B     = 18;
    localparam logic [4:0] STD_END_V = 5'h04;

    localparam logic [7:0] TT_EVENT = 8'hff;

    // mapping limits and preloads
    localparam logic [6:0] MAP_MAX       = 7'h40;
    localparam logic [6:0] MAP_FULL_BITS = 7'h40;
    localparam logic [6:0] MAP_DIG_CNT   = 7'h08;
    localparam logic [6:0] MAP_ANA_CNT   = 7'h04;
    localparam logic [6:0] MAP_ENC_CNT   = 7'h02;
    localparam logic [6:0] MAP_SER_CNT   = 7'h01;

    // io presence strap bits
    localparam int IO_DIG_IN  = 0;
    localparam int IO_ANA_IN  = 1;
    localparam int IO_DIG_OUT = 2;
    localparam int IO_ANA_OUT = 3;
    localparam int IO_ENC     = 4;
    localparam int IO_SER     = 5;

    // bus address layout
    localparam int REG_HI = 9;
    localparam int REG_LO = 8;
    localparam int IDX_HI = 7;
    localparam int IDX_LO = 2;
    localparam logic [1:0] REGION_COB = 2'h0;
    localparam logic [1:0] REGION_TT  = 2'h1;
    localparam logic [1:0] REGION_MAP = 2'h2;
    localparam logic [1:0] REGION_CTL = 2'h3;
    localparam logic [5:0] CTL_IDX    = 6'h00;
    localparam logic [5:0] STAT_IDX   = 6'h01;
    localparam int RESTORE_BIT = 0;
    localparam int MAP_ERR_BIT = 16;
    localparam int MAP_CNT_LO  = 0;
    localparam int MAP_BITS_LO = 16;
    localparam int STAT_IO_LO  = 8;

    localparam logic [1:0] INIT_CYCLES = 2'h3;
    localparam logic [1:0] INIT_LAST   = 2'h1;
    localparam logic       HRESP_OKAY  = 1'b0;

    typedef struct packed {
        logic [IO_W-1:0]   io;
        logic [NODE_W-1:0] node_id;
    } cpdo_strap_type;

    typedef struct packed {
        logic [6:0] bits;
        logic [6:0] count;
    } cpdo_map_type;
endpackage

// file: tb.sv
`timescale 1ns/1ps
module tb
    import cpdo_pkg::*;
;
    logic           clk, rst_b, hsel, hwrite, hreadyout, hresp;
    logic           rtr_valid, rx_valid, rtr_send, rx_hit;
    logic [1:0]     htrans;
    logic [2:0]     hsize;
    logic [4:0]     rtr_pdo, rtr_send_pdo, rx_pdo;
    logic [10:0]    rx_cob;
    logic [31:0]    haddr, hwdata, hrdata, app_event, tx_req, rd;
    cpdo_strap_type strap;
    int             seed, mismatches, tests_run;
    int             cyc = 0;

    cpdo_defaults cpdo_defaults_inst (
        .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .strap_pin(strap),
        .app_event(app_event), .rtr_valid(rtr_valid), .rtr_pdo(rtr_pdo),
        .rx_valid(rx_valid), .rx_cob(rx_cob), .tx_req(tx_req), .rtr_send(rtr_send),
        .rtr_send_pdo(rtr_send_pdo), .rx_hit(rx_hit), .rx_pdo(rx_pdo)
    );

    cpdo_partner cpdo_partner_inst (
        .clk(clk), .rtr_valid(rtr_valid), .rtr_pdo(rtr_pdo),
        .rx_valid(rx_valid), .rx_cob(rx_cob)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= a;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    function automatic logic [31:0] exp_cob(input int i, input logic [6:0] n,
                                            input logic [5:0] io);
        int          p;
        logic [31:0] b;
        p = i % 32;
        b = COB_STEP * (p % 4) + 32'(n);
        if (i >= 32) begin
            if (p >= STD_END)
                return COB_INVALID;
            return (io[p > 0 ? IO_ANA_OUT : IO_DIG_OUT] ? 32'h0 : COB_INVALID) | (b + RX_STD_BASE);
        end
        if (p < STD_END)
            return (io[p > 0 ? IO_ANA_IN : IO_DIG_IN] ? 32'h0 : COB_INVALID) | (b + TX_STD_BASE);
        if (p < DIG_END)
            return (p < DIG_SPLIT ? COB_INVALID : COB_INV_NORTR) | (b + TX_DIG_BASE);
        if (p < ENC_END)
            return COB_INV_NORTR | (b + TX_ENC_BASE);
        if (p < ANA_END)
            return COB_INV_NORTR | (b + TX_ANA_BASE);
        if (p == SER_A || p == SER_B)
            return COB_INV_NORTR;
        return COB_INVALID;
    endfunction

    task automatic reset_dut(input logic [6:0] n, input logic [5:0] io);
        strap <= {io, n};
        rst_b <= 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask

    task automatic check_defaults(input logic [6:0] n, input logic [5:0] io);
        for (int i = 0; i < NUM_PDO; i++) begin
            bus(1'b0, 32'(4 * i), 32'h0);
            chk("cob", exp_cob(i, n, io), rd);
            bus(1'b0, 32'(256 + 4 * i), 32'h0);
            chk("ttype", 32'(TT_EVENT), rd);
        end
        bus(1'b0, 32'h0000_0304, 32'h0);
        chk("status", {18'h0, io, 1'b0, n}, rd);
        chk("hresp", 32'h0, 32'(hresp));
        bus(1'b0, 32'h0000_0200, 32'h0);
        chk("map_def", io[IO_DIG_IN] ? 32'h0040_0008 : 32'h0, rd);
    endtask

    initial begin
        logic [6:0]  n;
        logic [5:0]  io;
        logic [3:0]  t;
        logic [4:0]  k;
        logic [7:0]  tt;
        logic [10:0] cob;
        logic        act;
        seed = 39219;
        mismatches = 0;
        tests_run = 0;
        rst_b = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        app_event = 32'h0;
        strap = 13'h0;
        n = 7'(1 + {$random(seed)} % 127);
        io = 6'($random(seed));
        reset_dut(n, io);
        check_defaults(n, io);
        for (int j = 0; j < 16; j++) begin
            t = 4'(j);
            k = 5'($random(seed));
            tt = (j % 3 == 0) ? 8'($random(seed)) : TT_EVENT;
            act = t < ACTIVE_LIMIT;
            cob = 11'h600 + 11'(j * 8);
            bus(1'b1, 32'(256 + 4 * k), 32'(tt));
            bus(1'b1, 32'(4 * k), {t, 17'h0, cob});
            app_event <= 32'h0000_0001 << k;
            @(posedge clk);
            app_event <= 32'h0;
            #1;
            chk("tx_req", (act && tt == TT_EVENT) ? 32'h0000_0001 << k : 32'h0, tx_req);
            cpdo_partner_inst.send_rtr(k, j % 4);
            #1;
            chk("rtr_send", 32'(act && !t[2]), 32'(rtr_send));
            if (act && !t[2])
                chk("rtr_pdo", 32'(k), 32'(rtr_send_pdo));
            bus(1'b1, 32'(128 + 4 * k), {t, 17'h0, cob});
            cpdo_partner_inst.send_frame(cob, j % 3);
            #1;
            chk("rx_hit", 32'(act), 32'(rx_hit));
            if (act)
                chk("rx_pdo", 32'(k), 32'(rx_pdo));
        end
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, 32'(i < 4 ? 4 * i : 112 + 4 * i), 32'h0);
            bus(1'b0, 32'(i < 4 ? 4 * i : 112 + 4 * i), 32'h0);
            chk("cob_zero", exp_cob(i < 4 ? i : 28 + i, n, 6'h3f), rd);
        end
        n = 7'(1 + {$random(seed)} % 127);
        reset_dut(n, 6'h00);
        check_defaults(n, 6'h00);
        for (int i = 1; i < 4; i++) begin
            bus(1'b0, 32'(512 + 4 * i), 32'h0);
            chk("map_tx", 32'h0, rd);
            bus(1'b0, 32'(640 + 4 * i), 32'h0);
            chk("map_rx", 32'h0, rd);
        end
        bus(1'b1, 32'h0000_0250, 32'h0040_0040);
        bus(1'b0, 32'h0000_0250, 32'h0);
        chk("map", 32'h0040_0040, rd);
        bus(1'b1, 32'h0000_0250, 32'h0010_0041);
        bus(1'b0, 32'h0000_0250, 32'h0);
        chk("map_keep", 32'h0040_0040, rd);
        bus(1'b0, 32'h0000_0304, 32'h0);
        chk("map_err", 32'h1, 32'(rd[16]));
        bus(1'b1, 32'h0000_0304, 32'h0001_0000);
        bus(1'b0, 32'h0000_0308, 32'h0);
        chk("unmapped", 32'h0, rd);
        n = 7'(1 + {$random(seed)} % 127);
        io = 6'($random(seed));
        strap <= {io, n};
        repeat (3) @(posedge clk);
        bus(1'b1, 32'h0000_0300, 32'h0000_0001);
        check_defaults(n, io);
        summarize();
    end
endmodule
